// ===== shared/i2cm_pkg.sv
package i2cm_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [2:0] ADDR_CONTROL_ONE = 3'h0; // Enable and mode select
  localparam logic [2:0] ADDR_CONTROL_TWO = 3'h1; // Request bits and ack result
  localparam logic [2:0] ADDR_STATUS = 3'h2; // Start/stop/buffer-full flags
  localparam logic [2:0] ADDR_BUFFER = 3'h3; // Shift buffer
  localparam logic [2:0] ADDR_RELOAD = 3'h4; // Baud reload value
  localparam logic [2:0] ADDR_FLAGS = 3'h5; // Irq, collision flags

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CON1_ENABLE_BIT = 5; // Module enable
  localparam int CON1_MODE_LSB = 0; // Mode select field, 4 bits
  localparam logic [3:0] MODE_MASTER = 4'h8; // Master encoding
  localparam int CON2_START_BIT = 0; // Start request
  localparam int CON2_RESTART_BIT = 1; // Repeated start request
  localparam int CON2_STOP_BIT = 2; // Stop request
  localparam int CON2_RECV_BIT = 3; // Receive a byte
  localparam int CON2_ACKEN_BIT = 4; // Send acknowledge
  localparam int CON2_ACKDT_BIT = 5; // Acknowledge value to send
  localparam int CON2_SLAVE_ACK_RESULT_BIT = 6; // Slave acknowledge result
  localparam int STAT_FULL_BIT = 0; // Buffer full
  localparam int STAT_START_BIT = 3; // Start detected
  localparam int STAT_STOP_BIT = 4; // Stop detected
  localparam int FLAG_IRQ_BIT = 0; // Port interrupt flag
  localparam int FLAG_WRITE_COLLISION_FLAG_BIT = 1; // Write collision flag
  localparam int FLAG_BCOL_BIT = 2; // Bus collision flag

  // ----------------------------------------------------------------
  // Widths and reset values
  // ----------------------------------------------------------------
  localparam int DATA_W = 8; // Byte width
  localparam int RELOAD_W = 7; // Baud reload width
  localparam int PHASE_W = 2; // Quarter-cycle phase counter
  localparam logic [7:0] ZERO_BYTE = 8'h00; // Reset value of registers
  localparam logic [6:0] RELOAD_RESET = 7'h09; // Default reload
  localparam logic [3:0] BITS_PER_BYTE = 4'h8; // Data bits per byte
  localparam logic [1:0] PHASE_Q2 = 2'h1; // Second internal phase
  localparam logic [1:0] PHASE_Q4 = 2'h3; // Fourth internal phase

  // ----------------------------------------------------------------
  // Bus engine states
  // ----------------------------------------------------------------
  typedef enum logic [9:0] {
    I2CM_IDLE = 10'b00_0000_0001, // Waiting for a request
    I2CM_ST_CHK = 10'b00_0000_0010, // Start: both lines high for a period
    I2CM_ST_HOLD = 10'b00_0000_0100, // Start: data low for a period
    I2CM_RS_LOW = 10'b00_0000_1000, // Restart: clock low, data released
    I2CM_BIT_LOW = 10'b00_0001_0000, // Bit: clock low half
    I2CM_BIT_HIGH = 10'b00_0010_0000, // Bit: clock high half
    I2CM_SP_LOW = 10'b00_0100_0000, // Stop: data low, clock low
    I2CM_SP_CLK = 10'b00_1000_0000, // Stop: clock released
    I2CM_SP_DAT = 10'b01_0000_0000, // Stop: data released
    I2CM_HOLD = 10'b10_0000_0000 // Clock held low after a byte or ack, left high after a start
  } i2cm_state_t;

  typedef enum logic [2:0] {
    I2CM_OP_START = 3'b001, // Start or repeated start in flight
    I2CM_OP_BYTE = 3'b010, // Byte or ack bit in flight
    I2CM_OP_STOP = 3'b100 // Stop in flight
  } i2cm_op_t;

endpackage

// ===== verilog/i2cm_master.sv
// Functional notes
// - Start/stop flags clear on reset, disable
// - No queueing: early buffer write sets collision
// - Interrupt flag on every completed event
// - Master drives clocks, restart keeps bus
// - Transmit: address then direction bit zero
// - Receive: address, direction one, then ack
// - Eight bits per byte, then ack
// - Generator reaches 100k, 400k, 1M rates
// - Start bit begins transaction, timing completes
// - Ninth bit sampled into ack result
// - Interrupt after ninth clock of sent byte, eighth when receiving
// - Stop bit; interrupt after stop completes
// - Reload from low seven reload bits
// - Buffer write starts generator counting
// - Counter stops at zero, reloads automatically
// - Counter decrements on phases two, four
// - Clock line holds after operation ends
// - Bus clock period is two rollovers
// - Instances independent, own reload each
// - Counter waits for clock sampled high
// - Start: check high, drive low, flag
// - Low line during start: bus collision
//
// Design decisions made here: the strobed register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none

module i2cm_master
  import i2cm_pkg::*;
#(
  parameter int RELOAD_WIDTH = RELOAD_W
)(
  input wire logic mclk,
  input wire logic reset,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic port_irq_flag
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Register write hit for one address
  function automatic logic wr_hit(input logic [2:0] a, input logic [2:0] want, input logic w);
    wr_hit = w && (a == want);
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  i2cm_state_t state_reg, state_next; // Bus engine state
  logic [7:0] port_control_one_reg, port_control_one_next; // Enable and mode
  logic start_request_bit_reg, start_request_bit_next; // Start request
  logic restart_request_bit_reg, restart_request_bit_next; // Restart request
  logic stop_request_bit_reg, stop_request_bit_next; // Stop request
  logic recv_req_reg, recv_req_next; // Receive-byte request
  logic ack_req_reg, ack_req_next; // Send-ack request
  logic ack_value_reg, ack_value_next; // Ack bit to send
  logic slave_ack_result_reg, slave_ack_result_next; // Sampled ack
  logic start_seen_reg, start_seen_next; // Start detected
  logic stop_seen_reg, stop_seen_next; // Stop detected
  logic buf_full_reg, buf_full_next; // Buffer full
  logic port_irq_flag_reg, port_irq_flag_next; // Event flag
  logic write_collision_flag_reg, write_collision_flag_next; // Write collision
  logic bus_collision_flag_reg, bus_collision_flag_next; // Bus collision
  logic [7:0] shift_buffer_reg, shift_buffer_next; // Software buffer
  logic [7:0] bit_shifter_reg, bit_shifter_next; // Shift register
  logic [RELOAD_WIDTH-1:0] slave_addr_or_baud_reload_reg, slave_addr_or_baud_reload_next; // Reload
  logic [RELOAD_WIDTH-1:0] baud_down_counter_reg, baud_down_counter_next; // Baud counter
  logic [PHASE_W-1:0] phase_reg, phase_next; // Internal phase
  logic [3:0] bit_cnt_reg, bit_cnt_next; // Bits left in frame
  logic rx_mode_reg, rx_mode_next; // Current byte is received
  logic ack_only_reg, ack_only_next; // Current frame is a lone ack bit
  logic scl_low_reg, scl_low_next; // Drive clock low
  logic sda_low_reg, sda_low_next; // Drive data low
  logic [7:0] rdata_reg, rdata_next; // Read data
  logic enabled; // Module enabled in master mode
  logic tick; // Counter decrement phase
  logic baud_done; // One baud period over
  logic busy; // Engine neither idle nor holding

  assign enabled = port_control_one_reg[CON1_ENABLE_BIT] &&
    (port_control_one_reg[CON1_MODE_LSB +: 4] == MODE_MASTER);
  assign tick = (phase_reg == PHASE_Q2) || (phase_reg == PHASE_Q4);
  assign baud_done = tick && (baud_down_counter_reg == '0);
  assign busy = (state_reg != I2CM_IDLE) && (state_reg != I2CM_HOLD);

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Bus engine, register writes and flags in one place so set beats clear
  always_comb
  begin
    state_next = state_reg;
    port_control_one_next = port_control_one_reg;
    start_request_bit_next = start_request_bit_reg;
    restart_request_bit_next = restart_request_bit_reg;
    stop_request_bit_next = stop_request_bit_reg;
    recv_req_next = recv_req_reg;
    ack_req_next = ack_req_reg;
    ack_value_next = ack_value_reg;
    slave_ack_result_next = slave_ack_result_reg;
    start_seen_next = start_seen_reg;
    stop_seen_next = stop_seen_reg;
    buf_full_next = buf_full_reg;
    port_irq_flag_next = port_irq_flag_reg;
    write_collision_flag_next = write_collision_flag_reg;
    bus_collision_flag_next = bus_collision_flag_reg;
    shift_buffer_next = shift_buffer_reg;
    bit_shifter_next = bit_shifter_reg;
    slave_addr_or_baud_reload_next = slave_addr_or_baud_reload_reg;
    baud_down_counter_next = baud_down_counter_reg;
    phase_next = phase_reg + 2'h1;
    bit_cnt_next = bit_cnt_reg;
    rx_mode_next = rx_mode_reg;
    ack_only_next = ack_only_reg;
    scl_low_next = scl_low_reg;
    sda_low_next = sda_low_reg;
    rdata_next = ZERO_BYTE;

    // Software writes: flags are cleared first, hardware sets later win
    if (wr_hit(reg_addr, ADDR_CONTROL_ONE, reg_write))
    begin
      port_control_one_next = reg_wdata;
    end
    if (wr_hit(reg_addr, ADDR_RELOAD, reg_write))
    begin
      slave_addr_or_baud_reload_next = reg_wdata[RELOAD_WIDTH-1:0];
    end
    if (wr_hit(reg_addr, ADDR_FLAGS, reg_write))
    begin
      // Write zero to clear a flag
      port_irq_flag_next = port_irq_flag_reg & reg_wdata[FLAG_IRQ_BIT];
      write_collision_flag_next = write_collision_flag_reg & reg_wdata[FLAG_WRITE_COLLISION_FLAG_BIT];
      bus_collision_flag_next = bus_collision_flag_reg & reg_wdata[FLAG_BCOL_BIT];
    end
    if (wr_hit(reg_addr, ADDR_CONTROL_TWO, reg_write))
    begin
      ack_value_next = reg_wdata[CON2_ACKDT_BIT];
      // Request bits locked while anything is in flight: no queueing
      if (state_reg == I2CM_IDLE || state_reg == I2CM_HOLD)
      begin
        start_request_bit_next = reg_wdata[CON2_START_BIT];
        restart_request_bit_next = reg_wdata[CON2_RESTART_BIT];
        stop_request_bit_next = reg_wdata[CON2_STOP_BIT];
        recv_req_next = reg_wdata[CON2_RECV_BIT];
        ack_req_next = reg_wdata[CON2_ACKEN_BIT];
      end
    end
    if (wr_hit(reg_addr, ADDR_BUFFER, reg_write))
    begin
      if (busy || start_request_bit_reg || restart_request_bit_reg)
      begin
        write_collision_flag_next = 1'b1;
      end
      else
      begin
        shift_buffer_next = reg_wdata;
        buf_full_next = 1'b1;
      end
    end

    // Counter runs on the two decrement phases
    if (tick && baud_down_counter_reg != '0)
    begin
      baud_down_counter_next = baud_down_counter_reg - 1'b1;
    end

    case (state_reg)
      I2CM_IDLE, I2CM_HOLD:
      begin
        // Clock line stays where the last operation left it
        if (enabled && start_request_bit_reg && state_reg == I2CM_IDLE)
        begin
          if (!scl_in || !sda_in)
          begin
            bus_collision_flag_next = 1'b1;
            start_request_bit_next = 1'b0;
          end
          else
          begin
            baud_down_counter_next = slave_addr_or_baud_reload_reg;
            state_next = I2CM_ST_CHK;
          end
        end
        else if (enabled && restart_request_bit_reg)
        begin
          scl_low_next = 1'b1;
          sda_low_next = 1'b0;
          baud_down_counter_next = slave_addr_or_baud_reload_reg;
          state_next = I2CM_RS_LOW;
        end
        else if (enabled && stop_request_bit_reg)
        begin
          scl_low_next = 1'b1;
          sda_low_next = 1'b1;
          baud_down_counter_next = slave_addr_or_baud_reload_reg;
          state_next = I2CM_SP_LOW;
        end
        else if (enabled && (buf_full_reg || recv_req_reg || ack_req_reg))
        begin
          // Byte transmit, receive or lone ack, starting with clock low
          bit_shifter_next = buf_full_reg ? shift_buffer_reg : ZERO_BYTE;
          rx_mode_next = !buf_full_reg && recv_req_reg;
          ack_only_next = !buf_full_reg && !recv_req_reg;
          bit_cnt_next = (!buf_full_reg && !recv_req_reg) ? 4'h0 : BITS_PER_BYTE;
          // Clock falls first, data follows in the low half
          scl_low_next = 1'b1;
          baud_down_counter_next = slave_addr_or_baud_reload_reg;
          state_next = I2CM_BIT_LOW;
        end
      end
      I2CM_ST_CHK:
      begin
        if (!scl_in || !sda_in)
        begin
          bus_collision_flag_next = 1'b1;
          start_request_bit_next = 1'b0;
          restart_request_bit_next = 1'b0;
          sda_low_next = 1'b0;
          scl_low_next = 1'b0;
          state_next = I2CM_IDLE;
        end
        else if (baud_done)
        begin
          sda_low_next = 1'b1;
          start_seen_next = 1'b1;
          stop_seen_next = 1'b0;
          baud_down_counter_next = slave_addr_or_baud_reload_reg;
          state_next = I2CM_ST_HOLD;
        end
      end
      I2CM_ST_HOLD:
      begin
        if (baud_done)
        begin
          start_request_bit_next = 1'b0;
          restart_request_bit_next = 1'b0;
          port_irq_flag_next = 1'b1;
          state_next = I2CM_HOLD;
        end
      end
      I2CM_RS_LOW:
      begin
        // Data released while clock low for one period, then clock up
        if (baud_done && scl_low_reg)
        begin
          scl_low_next = 1'b0;
        end
        else if (!scl_low_reg && scl_in)
        begin
          baud_down_counter_next = slave_addr_or_baud_reload_reg;
          state_next = I2CM_ST_CHK;
        end
        else if (!scl_low_reg)
        begin
          baud_down_counter_next = slave_addr_or_baud_reload_reg;
        end
      end
      I2CM_BIT_LOW:
      begin
        // Data moves one cycle after the clock fell, so no false start or stop
        if (ack_only_reg)
        begin
          sda_low_next = !ack_value_reg;
        end
        else
        begin
          sda_low_next = !rx_mode_reg && (bit_cnt_reg != 4'h0) && !bit_shifter_reg[DATA_W-1];
        end
        if (baud_done)
        begin
          scl_low_next = 1'b0;
          baud_down_counter_next = slave_addr_or_baud_reload_reg;
          state_next = I2CM_BIT_HIGH;
        end
      end
      I2CM_BIT_HIGH:
      begin
        if (!scl_in)
        begin
          // A slave holds the clock low: stretch the high half
          baud_down_counter_next = slave_addr_or_baud_reload_reg;
        end
        else if (baud_done)
        begin
          scl_low_next = 1'b1;
          baud_down_counter_next = slave_addr_or_baud_reload_reg;
          if (bit_cnt_reg == 4'h0)
          begin
            // Ninth bit over: ack captured, frame done
            if (!rx_mode_reg && !ack_only_reg)
            begin
              slave_ack_result_next = sda_in;
            end
            if (ack_only_reg)
            begin
              ack_req_next = 1'b0;
            end
            // Data left as is: never moved while the clock falls
            port_irq_flag_next = 1'b1;
            state_next = I2CM_HOLD;
          end
          else
          begin
            bit_shifter_next = {bit_shifter_reg[DATA_W-2:0], sda_in};
            bit_cnt_next = bit_cnt_reg - 4'h1;
            if (bit_cnt_reg == 4'h1)
            begin
              // Byte finished: release data for the slave's ack
              buf_full_next = 1'b0;
              if (rx_mode_reg)
              begin
                shift_buffer_next = {bit_shifter_reg[DATA_W-2:0], sda_in};
                recv_req_next = 1'b0;
                port_irq_flag_next = 1'b1;
                state_next = I2CM_HOLD;
              end
              else
              begin
                state_next = I2CM_BIT_LOW;
              end
            end
            else
            begin
              state_next = I2CM_BIT_LOW;
            end
          end
        end
      end
      I2CM_SP_LOW:
      begin
        if (baud_done)
        begin
          scl_low_next = 1'b0;
          state_next = I2CM_SP_CLK;
        end
      end
      I2CM_SP_CLK:
      begin
        if (!scl_in)
        begin
          baud_down_counter_next = slave_addr_or_baud_reload_reg;
        end
        else if (baud_done)
        begin
          sda_low_next = 1'b0;
          baud_down_counter_next = slave_addr_or_baud_reload_reg;
          state_next = I2CM_SP_DAT;
        end
      end
      I2CM_SP_DAT:
      begin
        if (baud_done)
        begin
          stop_request_bit_next = 1'b0;
          stop_seen_next = 1'b1;
          start_seen_next = 1'b0;
          port_irq_flag_next = 1'b1;
          state_next = I2CM_IDLE;
        end
      end
      default:
      begin
        state_next = I2CM_IDLE;
      end
    endcase

    // Disabling the port drops the engine and the bus flags
    if (!port_control_one_reg[CON1_ENABLE_BIT])
    begin
      start_seen_next = 1'b0;
      stop_seen_next = 1'b0;
      state_next = I2CM_IDLE;
      scl_low_next = 1'b0;
      sda_low_next = 1'b0;
    end

    // Read data, valid the cycle after the strobe
    if (reg_read)
    begin
      case (reg_addr)
        ADDR_CONTROL_ONE: rdata_next = port_control_one_reg;
        ADDR_CONTROL_TWO: rdata_next = {1'b0, slave_ack_result_reg, ack_value_reg, ack_req_reg,
          recv_req_reg, stop_request_bit_reg, restart_request_bit_reg, start_request_bit_reg};
        ADDR_STATUS: rdata_next = {3'b000, stop_seen_reg, start_seen_reg, 2'b00, buf_full_reg};
        ADDR_BUFFER: rdata_next = shift_buffer_reg;
        ADDR_RELOAD: rdata_next = {{(8-RELOAD_WIDTH){1'b0}}, slave_addr_or_baud_reload_reg};
        ADDR_FLAGS: rdata_next = {5'b00000, bus_collision_flag_reg, write_collision_flag_reg,
          port_irq_flag_reg};
        default: rdata_next = ZERO_BYTE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Synchronous reset to constants
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      state_reg <= I2CM_IDLE;
      port_control_one_reg <= ZERO_BYTE;
      start_request_bit_reg <= 1'b0;
      restart_request_bit_reg <= 1'b0;
      stop_request_bit_reg <= 1'b0;
      recv_req_reg <= 1'b0;
      ack_req_reg <= 1'b0;
      ack_value_reg <= 1'b0;
      slave_ack_result_reg <= 1'b0;
      start_seen_reg <= 1'b0;
      stop_seen_reg <= 1'b0;
      buf_full_reg <= 1'b0;
      port_irq_flag_reg <= 1'b0;
      write_collision_flag_reg <= 1'b0;
      bus_collision_flag_reg <= 1'b0;
      shift_buffer_reg <= ZERO_BYTE;
      bit_shifter_reg <= ZERO_BYTE;
      slave_addr_or_baud_reload_reg <= RELOAD_RESET[RELOAD_WIDTH-1:0];
      baud_down_counter_reg <= '0;
      phase_reg <= '0;
      bit_cnt_reg <= 4'h0;
      rx_mode_reg <= 1'b0;
      ack_only_reg <= 1'b0;
      scl_low_reg <= 1'b0;
      sda_low_reg <= 1'b0;
      rdata_reg <= ZERO_BYTE;
    end
    else
    begin
      state_reg <= state_next;
      port_control_one_reg <= port_control_one_next;
      start_request_bit_reg <= start_request_bit_next;
      restart_request_bit_reg <= restart_request_bit_next;
      stop_request_bit_reg <= stop_request_bit_next;
      recv_req_reg <= recv_req_next;
      ack_req_reg <= ack_req_next;
      ack_value_reg <= ack_value_next;
      slave_ack_result_reg <= slave_ack_result_next;
      start_seen_reg <= start_seen_next;
      stop_seen_reg <= stop_seen_next;
      buf_full_reg <= buf_full_next;
      port_irq_flag_reg <= port_irq_flag_next;
      write_collision_flag_reg <= write_collision_flag_next;
      bus_collision_flag_reg <= bus_collision_flag_next;
      shift_buffer_reg <= shift_buffer_next;
      bit_shifter_reg <= bit_shifter_next;
      slave_addr_or_baud_reload_reg <= slave_addr_or_baud_reload_next;
      baud_down_counter_reg <= baud_down_counter_next;
      phase_reg <= phase_next;
      bit_cnt_reg <= bit_cnt_next;
      rx_mode_reg <= rx_mode_next;
      ack_only_reg <= ack_only_next;
      scl_low_reg <= scl_low_next;
      sda_low_reg <= sda_low_next;
      rdata_reg <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Open drain: only ever pull low
  assign scl_out = 1'b0;
  assign scl_oe = scl_low_reg;
  assign sda_out = 1'b0;
  assign sda_oe = sda_low_reg;
  assign reg_rdata = rdata_reg;
  assign port_irq_flag = port_irq_flag_reg;

endmodule

`default_nettype wire

// ===== tb/i2cm_master_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module i2cm_master_monitor
  import i2cm_pkg::*;
#(
  parameter int RELOAD_WIDTH = RELOAD_W
)(
  input wire logic mclk,
  input wire logic reset,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic port_irq_flag
);
  // ----------------------------------------
  // Port checks, one clock domain
  // ----------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  a_open_drain: assert property (!scl_out && !sda_out) else $error("line driven high");
  a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == ZERO_BYTE) else $error("stray read data");
  a_irq_sticky: assert property (port_irq_flag && !reg_write |=> port_irq_flag) else $error("irq lost");
  // Start only out of lines seen high just before
  a_start_lines: assert property ($rose(sda_oe) && !scl_oe |-> $past(scl_in) && $past(sda_in))
    else $error("start on busy bus");
  // Held clock must not be pulled again while a slave stretches
  a_stretch_wait: assert property (!scl_oe && !scl_in |=> !scl_oe) else $error("stretch ignored");
  a_scl_high_min: assert property ($rose(scl_in) |=> !scl_oe [*3]) else $error("short high");
  a_scl_low_min: assert property ($rose(scl_oe) |=> scl_oe [*3]) else $error("short low");
  a_irq_hold_scl: assert property ($rose(port_irq_flag) && scl_oe |=> scl_oe [*3])
    else $error("clock not held");
endmodule
`default_nettype wire

// ===== tb/i2cm_slave_model.sv
`timescale 1ns/100ps
`default_nettype none
module i2cm_slave_model #(
  parameter logic [6:0] ADDR = 7'h2a,
  parameter logic [7:0] RDATA = 8'ha5
)(
  input wire logic scl,
  input wire logic sda,
  input wire logic stretch,
  output logic sda_low = 1'b0,
  output logic scl_low = 1'b0
);
  logic [7:0] sh = 8'h00; // Bits seen on the wire
  logic [7:0] rx = 8'h00; // Last whole byte
  int n = 0; // Bit count in frame
  logic first = 1'b0; // Address byte pending
  logic act = 1'b0; // Addressed
  logic rd = 1'b0; // Read direction
  // ----------------------------------------
  // Frame tracking, lines have pull-ups
  // ----------------------------------------
  always @(negedge sda)
    if (scl)
    begin
      n = 0;
      first = 1'b1;
    end
  always @(posedge sda)
    if (scl)
      act = 1'b0;
  always @(posedge scl)
  begin
    sh = {sh[6:0], sda}; // MSB first
    n = n + 1;
    if (n == 8)
      rx = sh;
  end
  // Change data only at the clock's falling edge
  always @(negedge scl)
  begin
    sda_low = 1'b0;
    if (n == 8 && first)
    begin
      act = (sh[7:1] == ADDR);
      rd = sh[0];
    end
    if (n == 8 && act && (first || !rd))
      sda_low = 1'b1; // Ack after eight bits
    if (n == 9)
    begin
      n = 0;
      first = 1'b0;
    end
    if (act && rd && !first && n < 8)
      sda_low = !RDATA[7 - n]; // Read data
  end
  // Slow answer: hold the clock low a while
  always @(negedge scl)
    if (stretch)
    begin
      scl_low = 1'b1;
      #610 scl_low = 1'b0; // Off the clock edge
    end
endmodule
`default_nettype wire

// ===== tb/i2cm_master_tb.sv
`timescale 1ns/100ps
`default_nettype none
module i2cm_master_tb
  import i2cm_pkg::*;
;
  logic mclk = 0, reset = 1, reg_write = 0, reg_read = 0, stretch = 0;
  logic [2:0] reg_addr = 0;
  logic [7:0] reg_wdata = 0, reg_rdata;
  logic scl_in, scl_out, scl_oe, sda_in, sda_out, sda_oe, port_irq_flag, sda_low, scl_low;
  int mismatches = 0, num_checks = 0;
  always #25 mclk = ~mclk;
  // Open-drain wire levels from all parties
  assign scl_in = !(scl_oe || scl_low);
  assign sda_in = !(sda_oe || sda_low);
  i2cm_master i_dut(.mclk, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .scl_in, .scl_out, .scl_oe, .sda_in, .sda_out, .sda_oe, .port_irq_flag);
  i2cm_slave_model i_slv(.scl(scl_in), .sda(sda_in), .stretch, .sda_low, .scl_low);
  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task automatic give_verdict;
    if (mismatches == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("Error %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge mclk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] m, input logic [7:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge mclk);
    reg_read <= 1'b0;
    #1 chk(reg_rdata & m, exp);
  endtask
  // Bounded wait for the event flag, check flags, clear them
  task automatic ev(input logic [7:0] f);
    repeat (4000) if (port_irq_flag !== 1'b1) @(negedge mclk);
    rd(ADDR_FLAGS, 8'h07, f);
    wr(ADDR_FLAGS, 8'h00);
  endtask
  task automatic xfer(input logic [7:0] b, input logic [7:0] ack);
    wr(ADDR_BUFFER, b);
    ev(8'h01);
    rd(ADDR_CONTROL_TWO, 8'h40, ack);
    chk(i_slv.rx, b);
  endtask
  initial
  begin
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    rd(ADDR_RELOAD, 8'hff, 8'h09);
    rd(3'h7, 8'hff, 8'h00);
    rd(ADDR_STATUS, 8'h18, 8'h00);
    wr(ADDR_RELOAD, 8'h02);
    wr(ADDR_CONTROL_ONE, 8'h28);
    wr(ADDR_CONTROL_TWO, 8'h01);
    wr(ADDR_BUFFER, 8'h55);
    ev(8'h03);
    rd(ADDR_STATUS, 8'h19, 8'h08);
    rd(ADDR_CONTROL_TWO, 8'h01, 8'h00);
    xfer({7'h2a, 1'b0}, 8'h00);
    xfer(8'h3c, 8'h00);
    wr(ADDR_CONTROL_TWO, 8'h02);
    ev(8'h01);
    xfer({7'h2a, 1'b1}, 8'h00);
    stretch <= 1'b1;
    wr(ADDR_CONTROL_TWO, 8'h08);
    ev(8'h01);
    stretch <= 1'b0;
    rd(ADDR_BUFFER, 8'hff, 8'ha5);
    wr(ADDR_CONTROL_TWO, 8'h10);
    ev(8'h01);
    wr(ADDR_CONTROL_TWO, 8'h04);
    ev(8'h01);
    rd(ADDR_STATUS, 8'h18, 8'h10);
    wr(ADDR_CONTROL_TWO, 8'h01);
    ev(8'h01);
    xfer({7'h2b, 1'b0}, 8'h40);
    wr(ADDR_CONTROL_TWO, 8'h04);
    ev(8'h01);
    wr(ADDR_CONTROL_ONE, 8'h00);
    rd(ADDR_STATUS, 8'h18, 8'h00);
    give_verdict;
  end
  // Hang guard, far beyond the expected run
  initial
  begin
    #1000000;
    mismatches++;
    give_verdict;
  end
endmodule
bind i2cm_master i2cm_master_monitor #(.RELOAD_WIDTH(RELOAD_WIDTH)) i_mon(.mclk, .reset, .reg_addr,
  .reg_wdata, .reg_write, .reg_read, .reg_rdata, .scl_in, .scl_out, .scl_oe, .sda_in, .sda_out,
  .sda_oe, .port_irq_flag);
`default_nettype wire
